// ---- include/dtc_consts.svh ----
// Register indices, field positions, reset values and divider counts
// for the dual timer/counter.
// Assumes inclusion by bare name from the design and bench files.
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define DTC_IDX_RUNFLAGS 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_CNT0_LOW 8'h8a
`define DTC_IDX_CNT1_LOW 8'h8b
`define DTC_IDX_CNT0_HIGH 8'h8c
`define DTC_IDX_CNT1_HIGH 8'h8d
`define DTC_IDX_CLKSEL 8'h8e
`define DTC_IDX_GATECFG 8'h90

// Field positions in the run/flag register.
`define DTC_BIT_FLAG1 7
`define DTC_BIT_RUN1 6
`define DTC_BIT_FLAG0 5
`define DTC_BIT_RUN0 4

// Field positions in the clock-select register.
`define DTC_BIT_SYSSEL1 3
`define DTC_BIT_SYSSEL0 2

// Field positions in the gate polarity register.
`define DTC_BIT_POL1 1
`define DTC_BIT_POL0 0

// Reset value of every register.
`define DTC_RESET_BYTE 8'h00

// Prescaler terminal counts: the division ratio minus one.
`define DTC_DIV12_LAST 6'h0b
`define DTC_DIV4_LAST 6'h03
`define DTC_DIV48_LAST 6'h2f
`define DTC_DIV8_LAST 6'h07

`endif

// ---- include/dtc_pkg.sv ----
// Types shared by the dual timer/counter and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT = 2'b00,
        DTC_MODE_16BIT = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_t;

    // One timer's half of the mode register.
    typedef struct packed {
        logic gate_enable;
        logic event_count_sel;
        dtc_mode_t mode_field;
    } dtc_tcfg_t;

    // Whole mode register, timer 1 in the upper nibble.
    typedef struct packed {
        dtc_tcfg_t t1;
        dtc_tcfg_t t0;
    } dtc_timer_mode_reg_t;

    // Result of one counting step.
    typedef struct packed {
        logic ovf;
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_t;

endpackage

// ---- rtl/dtc_top.sv ----
// Dual 16-bit timer/counter with shared prescaler and clock-select register,
// reached over a classic Wishbone slave with 32-bit data.
// Assumes one 40 MHz clock; event, gate and external clock pins are async.
`timescale 1ns/1ps
`include "dtc_consts.svh"

module dtc_top
    import dtc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic [9:2] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Asynchronous pins.
    input wire logic event_pin0_i,
    input wire logic event_pin1_i,
    input wire logic gate_input0_i,
    input wire logic gate_input1_i,
    input wire logic ext_clk_i,
    // Interrupt controller vector acknowledges.
    input wire logic vector_ack0_i,
    input wire logic vector_ack1_i,
    // Flags, overflow pulse and clock selects for timers 2 and 3.
    output logic overflow_flag0_o,
    output logic overflow_flag1_o,
    output logic t1_overflow_pulse_o,
    output logic tmr2_low_sysclk_sel_o,
    output logic tmr2_high_sysclk_sel_o,
    output logic tmr3_low_sysclk_sel_o,
    output logic tmr3_high_sysclk_sel_o
);

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [5:0] div_last(input logic [1:0] sel);
        logic [5:0] last;
        last = `DTC_DIV12_LAST;
        unique case (sel)
            2'b00: last = `DTC_DIV12_LAST;
            2'b01: last = `DTC_DIV4_LAST;
            2'b10: last = `DTC_DIV48_LAST;
            2'b11: last = `DTC_DIV8_LAST;
        endcase
        return last;
    endfunction

    function automatic dtc_count_t count_step(input dtc_mode_t mode,
                                              input logic [7:0] low,
                                              input logic [7:0] high);
        dtc_count_t res;
        logic [12:0] sum13;
        logic [15:0] sum16;
        res = '{ovf: 1'b0, high: high, low: low};
        sum13 = {high, low[4:0]} + 13'h0001;
        sum16 = {high, low} + 16'h0001;
        unique case (mode)
            DTC_MODE_13BIT:
            begin
                res.ovf = &{high, low[4:0]};
                res.high = sum13[12:5];
                res.low = {low[7:5], sum13[4:0]};
            end
            DTC_MODE_16BIT:
            begin
                res.ovf = &{high, low};
                res.high = sum16[15:8];
                res.low = sum16[7:0];
            end
            DTC_MODE_RELOAD:
            begin
                res.ovf = &low;
                res.low = (&low) ? high : sum16[7:0];
            end
            DTC_MODE_SPLIT:
            begin
                res.ovf = &low;
                res.low = sum16[7:0];
            end
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0] clksel_reg;
    dtc_timer_mode_reg_t mode_reg;
    logic [1:0] gate_pol_reg;
    logic run0_reg;
    logic run1_reg;
    logic flag0_reg;
    logic flag1_reg;
    logic [7:0] cnt0_low_reg;
    logic [7:0] cnt0_high_reg;
    logic [7:0] cnt1_low_reg;
    logic [7:0] cnt1_high_reg;
    logic [5:0] presc_reg;
    logic presc_tick_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic t1_pulse_reg;
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync3_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the third stage only feeds edge detection.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            sync3_reg <= 5'h00;
        end
        else
        begin
            sync1_reg <= {ext_clk_i, gate_input1_i, gate_input0_i,
                          event_pin1_i, event_pin0_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    logic fall0;
    logic fall1;
    logic ext_rise;
    logic gate_lvl0;
    logic gate_lvl1;

    assign fall0 = ~sync2_reg[0] & sync3_reg[0];
    assign fall1 = ~sync2_reg[1] & sync3_reg[1];
    assign gate_lvl0 = sync2_reg[2];
    assign gate_lvl1 = sync2_reg[3];
    assign ext_rise = sync2_reg[4] & ~sync3_reg[4];

    ////////////////////////////////////////////////////////////////////////
    // Shared prescaler. A select change mid-count takes effect at once,
    // which can shorten one period; a glitch-free switch was not worth it.

    logic presc_adv;
    logic presc_last;

    assign presc_adv = (clksel_reg[1:0] == 2'b11) ? ext_rise : 1'b1;
    assign presc_last = presc_reg >= div_last(clksel_reg[1:0]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            presc_reg <= 6'h00;
            presc_tick_reg <= 1'b0;
        end
        else
        begin
            presc_tick_reg <= presc_adv & presc_last;
            if (presc_adv)
            begin
                presc_reg <= presc_last ? 6'h00 : presc_reg + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count enables and steps.

    logic split;
    logic tclk0;
    logic tclk1;
    logic src0;
    logic src1;
    logic gate_ok0;
    logic gate_ok1;
    logic en0;
    logic en0_high;
    logic en1;
    dtc_count_t step0;
    dtc_count_t step1;
    logic set_flag0;
    logic set_flag1;
    logic t1_wrap;

    assign split = mode_reg.t0.mode_field == DTC_MODE_SPLIT;
    assign tclk0 = clksel_reg[`DTC_BIT_SYSSEL0] | presc_tick_reg;
    assign tclk1 = clksel_reg[`DTC_BIT_SYSSEL1] | presc_tick_reg;
    assign src0 = mode_reg.t0.event_count_sel ? fall0 : tclk0;
    assign src1 = (mode_reg.t1.event_count_sel & ~split) ? fall1 : tclk1;

    assign gate_ok0 = ~mode_reg.t0.gate_enable |
                      (gate_lvl0 == gate_pol_reg[`DTC_BIT_POL0]);
    assign gate_ok1 = ~mode_reg.t1.gate_enable |
                      (gate_lvl1 == gate_pol_reg[`DTC_BIT_POL1]);

    assign en0 = run0_reg & gate_ok0 & src0;
    assign en0_high = split & run1_reg & tclk0;
    assign en1 = (split | run1_reg) & gate_ok1 &
                 (mode_reg.t1.mode_field != DTC_MODE_SPLIT) & src1;

    assign step0 = count_step(mode_reg.t0.mode_field, cnt0_low_reg,
                              cnt0_high_reg);
    assign step1 = count_step(mode_reg.t1.mode_field, cnt1_low_reg,
                              cnt1_high_reg);

    assign t1_wrap = en1 & step1.ovf;
    assign set_flag0 = en0 & step0.ovf;
    // flag 1 owned by high byte
    assign set_flag1 = split ? (en0_high & (&cnt0_high_reg)) : t1_wrap;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, writes land on the acknowledged edge.

    logic bus_req;
    logic wr_lane;
    logic wr_clksel;
    logic wr_mode;
    logic wr_gatecfg;
    logic wr_runflags;
    logic wr_c0l;
    logic wr_c0h;
    logic wr_c1l;
    logic wr_c1h;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    assign bus_req = cyc_i & stb_i;
    assign wr_lane = bus_req & we_i & ack_reg & sel_i[0];
    assign wbyte = dat_i[7:0];
    assign wr_clksel = wr_lane & (adr_i == `DTC_IDX_CLKSEL);
    assign wr_mode = wr_lane & (adr_i == `DTC_IDX_MODE);
    assign wr_gatecfg = wr_lane & (adr_i == `DTC_IDX_GATECFG);
    assign wr_runflags = wr_lane & (adr_i == `DTC_IDX_RUNFLAGS);
    assign wr_c0l = wr_lane & (adr_i == `DTC_IDX_CNT0_LOW);
    assign wr_c0h = wr_lane & (adr_i == `DTC_IDX_CNT0_HIGH);
    assign wr_c1l = wr_lane & (adr_i == `DTC_IDX_CNT1_LOW);
    assign wr_c1h = wr_lane & (adr_i == `DTC_IDX_CNT1_HIGH);

    always_comb
    begin
        rbyte = 8'h00;
        unique case (adr_i)
            `DTC_IDX_CLKSEL: rbyte = clksel_reg;
            `DTC_IDX_MODE: rbyte = mode_reg;
            `DTC_IDX_GATECFG: rbyte = {6'h00, gate_pol_reg};
            `DTC_IDX_RUNFLAGS: rbyte = {flag1_reg, run1_reg, flag0_reg,
                                        run0_reg, 4'h0};
            `DTC_IDX_CNT0_LOW: rbyte = cnt0_low_reg;
            `DTC_IDX_CNT0_HIGH: rbyte = cnt0_high_reg;
            `DTC_IDX_CNT1_LOW: rbyte = cnt1_low_reg;
            `DTC_IDX_CNT1_HIGH: rbyte = cnt1_high_reg;
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req & ~ack_reg)
            begin
                rdata_reg <= {24'h00_0000, rbyte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clksel_reg <= `DTC_RESET_BYTE;
            mode_reg <= `DTC_RESET_BYTE;
            gate_pol_reg <= 2'h0;
        end
        else
        begin
            // timer 2 and 3 selects held
            if (wr_clksel)
            begin
                clksel_reg <= wbyte;
            end
            if (wr_mode)
            begin
                mode_reg <= wbyte;
            end
            if (wr_gatecfg)
            begin
                gate_pol_reg <= wbyte[1:0];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run0_reg <= 1'b0;
            run1_reg <= 1'b0;
        end
        else if (wr_runflags)
        begin
            run0_reg <= wbyte[`DTC_BIT_RUN0];
            run1_reg <= wbyte[`DTC_BIT_RUN1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overflow flags: a hardware set beats a software or vector clear.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flag0_reg <= 1'b0;
            flag1_reg <= 1'b0;
        end
        else
        begin
            if (set_flag0)
            begin
                flag0_reg <= 1'b1;
            end
            else if (wr_runflags)
            begin
                flag0_reg <= wbyte[`DTC_BIT_FLAG0];
            end
            else if (vector_ack0_i)
            begin
                flag0_reg <= 1'b0;
            end
            if (set_flag1)
            begin
                flag1_reg <= 1'b1;
            end
            else if (wr_runflags)
            begin
                flag1_reg <= wbyte[`DTC_BIT_FLAG1];
            end
            else if (vector_ack1_i)
            begin
                flag1_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter bytes.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt0_low_reg <= `DTC_RESET_BYTE;
            cnt0_high_reg <= `DTC_RESET_BYTE;
        end
        else
        begin
            if (wr_c0l)
            begin
                cnt0_low_reg <= wbyte;
            end
            else if (en0)
            begin
                cnt0_low_reg <= step0.low;
            end
            if (wr_c0h)
            begin
                cnt0_high_reg <= wbyte;
            end
            else if (en0_high)
            begin
                cnt0_high_reg <= cnt0_high_reg + 8'h01;
            end
            else if (en0 & ~split)
            begin
                cnt0_high_reg <= step0.high;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt1_low_reg <= `DTC_RESET_BYTE;
            cnt1_high_reg <= `DTC_RESET_BYTE;
        end
        else
        begin
            if (wr_c1l)
            begin
                cnt1_low_reg <= wbyte;
            end
            else if (en1)
            begin
                cnt1_low_reg <= step1.low;
            end
            if (wr_c1h)
            begin
                cnt1_high_reg <= wbyte;
            end
            else if (en1)
            begin
                cnt1_high_reg <= step1.high;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            t1_pulse_reg <= 1'b0;
        end
        else
        begin
            t1_pulse_reg <= t1_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign dat_o = rdata_reg;
    assign ack_o = ack_reg;
    assign overflow_flag0_o = flag0_reg;
    assign overflow_flag1_o = flag1_reg;
    assign t1_overflow_pulse_o = t1_pulse_reg;
    assign tmr2_low_sysclk_sel_o = clksel_reg[4];
    assign tmr2_high_sysclk_sel_o = clksel_reg[5];
    assign tmr3_low_sysclk_sel_o = clksel_reg[6];
    assign tmr3_high_sysclk_sel_o = clksel_reg[7];

endmodule

// ---- bench/dtc_top_sva.sv ----
// Checker on the bus, flag and clock-select ports of the dual timer.
// Assumes it is bound to dtc_top, one clock and an active-high reset.
`timescale 1ns/1ps
`include "dtc_consts.svh"

module dtc_top_sva (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus.
    input wire logic [9:2] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Flags and selects.
    input wire logic vector_ack0_i,
    input wire logic vector_ack1_i,
    input wire logic overflow_flag0_o,
    input wire logic overflow_flag1_o,
    input wire logic t1_overflow_pulse_o,
    input wire logic tmr2_low_sysclk_sel_o,
    input wire logic tmr2_high_sysclk_sel_o,
    input wire logic tmr3_low_sysclk_sel_o,
    input wire logic tmr3_high_sysclk_sel_o
);
    logic wr_ok;
    logic wr_run;
    logic wr_clk;
    logic mapped;
    logic [3:0] sel_reg;
    logic [3:0] sel_out;

    assign wr_ok = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign wr_run = wr_ok && adr_i == `DTC_IDX_RUNFLAGS;
    assign wr_clk = wr_ok && adr_i == `DTC_IDX_CLKSEL;
    assign mapped = (adr_i >= 8'h88 && adr_i <= 8'h8e) || adr_i == 8'h90;
    assign sel_out = {tmr3_high_sysclk_sel_o, tmr3_low_sysclk_sel_o,
                      tmr2_high_sysclk_sel_o, tmr2_low_sysclk_sel_o};

    // Keeps the written nibble, since the master may change data later.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sel_reg <= 4'h0;
        else if (wr_clk)
            sel_reg <= dat_i[7:4];
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after a request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_zero: assert property (ack_o && !we_i && !mapped
        |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_runflag_low: assert property (ack_o && !we_i
        && adr_i == `DTC_IDX_RUNFLAGS |-> dat_o[3:0] == 4'h0)
        else $error("unused run/flag bits not zero");
    a_clksel_out: assert property (
        wr_clk |=> ##[0:1] sel_out == sel_reg)
        else $error("clock selects for timers 2 and 3 not driven");
    a_flag0_fall: assert property (
        $fell(overflow_flag0_o) |-> $past(vector_ack0_i)
        || ($past(wr_run) && !$past(dat_i[5])))
        else $error("flag 0 cleared without cause");
    a_flag1_fall: assert property (
        $fell(overflow_flag1_o) |-> $past(vector_ack1_i)
        || ($past(wr_run) && !$past(dat_i[7])))
        else $error("flag 1 cleared without cause");
    a_flag_swset: assert property (
        wr_run && dat_i[5] && !vector_ack0_i |=> overflow_flag0_o)
        else $error("flag 0 not set by software");
    a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !ack_o && !overflow_flag0_o && !overflow_flag1_o
        && !t1_overflow_pulse_o)
        else $error("outputs active after reset edge");
endmodule

bind dtc_top dtc_top_sva dtc_top_sva_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .adr_i(adr_i),
    .dat_i(dat_i),
    .sel_i(sel_i),
    .we_i(we_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .vector_ack0_i(vector_ack0_i),
    .vector_ack1_i(vector_ack1_i),
    .overflow_flag0_o(overflow_flag0_o),
    .overflow_flag1_o(overflow_flag1_o),
    .t1_overflow_pulse_o(t1_overflow_pulse_o),
    .tmr2_low_sysclk_sel_o(tmr2_low_sysclk_sel_o),
    .tmr2_high_sysclk_sel_o(tmr2_high_sysclk_sel_o),
    .tmr3_low_sysclk_sel_o(tmr3_low_sysclk_sel_o),
    .tmr3_high_sysclk_sel_o(tmr3_high_sysclk_sel_o)
);

// ---- bench/dtc_pins.sv ----
// Model of the pins around the timer: event pins, gates, external clock.
// Assumes the bench calls its tasks; pins change just after a clock edge.
`timescale 1ns/1ps

module dtc_pins (
    // Clock.
    input wire logic clk_i,
    // Pins seen by the timer.
    output logic event_pin0_o,
    output logic event_pin1_o,
    output logic gate_input0_o,
    output logic gate_input1_o,
    output logic ext_clk_o
);
    // Event pins idle high, the external clock idles low between bursts.
    logic [2:0] line_reg = 3'b011;
    logic [1:0] gate_reg = 2'b00;

    assign event_pin0_o = line_reg[0];
    assign event_pin1_o = line_reg[1];
    assign ext_clk_o = line_reg[2];
    assign gate_input0_o = gate_reg[0];
    assign gate_input1_o = gate_reg[1];

    task automatic hold4();
        repeat (4) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // slow pin levels
    // Each level stands four clocks, well inside the sampling limit.
    task pulse(input int pin, input int n);
        for (int k = 0; k < n; k++)
        begin
            line_reg[pin] <= ~line_reg[pin];
            hold4();
            line_reg[pin] <= ~line_reg[pin];
            hold4();
        end
    endtask

    task set_gate(input int g, input logic v);
        gate_reg[g] <= v;
        hold4();
    endtask
endmodule

// ---- bench/tb_dtc_top.sv ----
// Self-checking bench for the dual timer: bus tasks and pin model.
// Assumes dtc_top with its checker bound and the dtc_pins model.
`timescale 1ns/1ps
`include "dtc_consts.svh"

module tb_dtc_top;
    import dtc_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic vec0 = 1'b0;
    logic vec1 = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic ev0, ev1, gt0, gt1, xclk;
    logic fl0, fl1, pul;
    logic [3:0] tsel;
    logic [7:0] rv, rv2;
    int errors = 0, tests_run = 0;
    logic [7:0] lo_t [4] = '{8'h27, 8'h77, 8'h09, 8'h02};
    logic [7:0] hi_t [4] = '{8'h2a, 8'h7a, 8'h0c, 8'h03};

    initial forever #12.5 clk_i = ~clk_i;

    dtc_top dtc_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
        .dat_i(dat_w), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
        .dat_o(dat_o), .ack_o(ack_o), .event_pin0_i(ev0),
        .event_pin1_i(ev1), .gate_input0_i(gt0), .gate_input1_i(gt1),
        .ext_clk_i(xclk), .vector_ack0_i(vec0), .vector_ack1_i(vec1),
        .overflow_flag0_o(fl0), .overflow_flag1_o(fl1),
        .t1_overflow_pulse_o(pul), .tmr2_low_sysclk_sel_o(tsel[0]),
        .tmr2_high_sysclk_sel_o(tsel[1]), .tmr3_low_sysclk_sel_o(tsel[2]),
        .tmr3_high_sysclk_sel_o(tsel[3]));

    dtc_pins dtc_pins_i (.clk_i(clk_i), .event_pin0_o(ev0),
        .event_pin1_o(ev1), .gate_input0_o(gt0), .gate_input1_o(gt1),
        .ext_clk_o(xclk));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask

    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo,
                           input logic [7:0] hi);
        tests_run++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
            errors++;
        end
    endtask

    // Classic cycle: hold the request until ack is sampled, then release.
    task automatic wb(input logic [7:0] idx, input logic wr,
                      input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= idx;
        we <= wr;
        dat_w <= {24'h0, wd};
        sel <= 4'h1;
        cyc <= 1'b1;
        stb <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        chk({7'h0, n < 50}, 8'h01);
        rd = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        wb(idx, 1'b1, d, x);
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        wb(idx, 1'b0, 8'h00, x);
        chk(x, exp);
    endtask

    // Bounded wait for flag 0, flag 1 or the overflow pulse.
    task automatic wait_on(input int w);
        logic s;
        s = 1'b0;
        for (int k = 0; k < 300 && s !== 1'b1; k++)
        begin
            @(posedge clk_i);
            s = (w == 0) ? fl0 : (w == 1) ? fl1 : pul;
        end
        chk({7'h0, s}, 8'h01);
    endtask

    task automatic vec(input int w);
        @(posedge clk_i);
        if (w == 0)
            vec0 <= 1'b1;
        else
            vec1 <= 1'b1;
        @(posedge clk_i);
        vec0 <= 1'b0;
        vec1 <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    initial
    begin
        repeat (30000) @(posedge clk_i);
        errors++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`DTC_IDX_CLKSEL, 8'h00); // Reset value.
        rd_chk(`DTC_IDX_MODE, 8'h00); // Reset value.
        wr(`DTC_IDX_CLKSEL, 8'hf0); // store selects
        rd_chk(`DTC_IDX_CLKSEL, 8'hf0); // read back
        chk({4'h0, tsel}, 8'h0f); // selects driven out
        rd_chk(8'h91, 8'h00); // Unmapped place reads zero.
        wr(`DTC_IDX_CLKSEL, 8'h00);
        $display("test registers done");
        // Timer 0 counts events in reload mode.
        wr(`DTC_IDX_MODE, 8'h06);
        wr(`DTC_IDX_CNT0_HIGH, 8'hf0);
        wr(`DTC_IDX_CNT0_LOW, 8'hfe);
        wr(`DTC_IDX_RUNFLAGS, 8'h10);
        dtc_pins_i.pulse(0, 3); // falling edges
        repeat (6) @(posedge clk_i);
        rd_chk(`DTC_IDX_CNT0_LOW, 8'hf1); // reload from high
        rd_chk(`DTC_IDX_CNT0_HIGH, 8'hf0); // high unchanged
        chk({7'h0, fl0}, 8'h01); // flag set on wrap
        vec(0);
        chk({7'h0, fl0}, 8'h00); // cleared on vector
        wr(`DTC_IDX_RUNFLAGS, 8'h20);
        chk({7'h0, fl0}, 8'h01); // software sets flag
        wr(`DTC_IDX_RUNFLAGS, 8'h00);
        $display("test reload done");
        // Gated 16-bit event count, gate active high.
        wr(`DTC_IDX_MODE, 8'h0d);
        wr(`DTC_IDX_GATECFG, 8'h01);
        wr(`DTC_IDX_CNT0_HIGH, 8'h00);
        wr(`DTC_IDX_CNT0_LOW, 8'h10);
        wr(`DTC_IDX_RUNFLAGS, 8'h10);
        dtc_pins_i.pulse(0, 2);
        rd_chk(`DTC_IDX_CNT0_LOW, 8'h10); // gate closed holds
        dtc_pins_i.set_gate(0, 1'b1);
        dtc_pins_i.pulse(0, 2);
        repeat (6) @(posedge clk_i);
        rd_chk(`DTC_IDX_CNT0_LOW, 8'h12); // count kept on run
        wr(`DTC_IDX_RUNFLAGS, 8'h00);
        dtc_pins_i.set_gate(0, 1'b0);
        $display("test gate done");
        // Timer 1, 13-bit event count wraps at the top.
        wr(`DTC_IDX_MODE, 8'h40);
        wr(`DTC_IDX_CNT1_HIGH, 8'hff);
        wr(`DTC_IDX_CNT1_LOW, 8'h1e);
        wr(`DTC_IDX_RUNFLAGS, 8'h40);
        dtc_pins_i.pulse(1, 2); // own pin
        repeat (6) @(posedge clk_i);
        rd_chk(`DTC_IDX_CNT1_HIGH, 8'h00); // wraps at 13 bits
        rd_chk(`DTC_IDX_CNT1_LOW, 8'h00); // low part wraps
        chk({7'h0, fl1}, 8'h01); // flag set on wrap
        wr(`DTC_IDX_RUNFLAGS, 8'h00);
        chk({7'h0, fl1}, 8'h00); // software clears flag
        $display("test mode0 done");
        // Timer 0, 16-bit on the system clock.
        wr(`DTC_IDX_CLKSEL, 8'h04);
        wr(`DTC_IDX_MODE, 8'h01);
        wr(`DTC_IDX_CNT0_HIGH, 8'hff);
        wr(`DTC_IDX_CNT0_LOW, 8'hff);
        wr(`DTC_IDX_RUNFLAGS, 8'h10);
        wait_on(0); // 16-bit wrap
        wr(`DTC_IDX_RUNFLAGS, 8'h00);
        $display("test mode1 done");
        // Prescaler codes; the count window is bounded by two writes.
        for (int c = 0; c < 4; c++)
        begin
            wr(`DTC_IDX_CLKSEL, c[7:0]);
            wr(`DTC_IDX_CNT0_LOW, 8'h00);
            wr(`DTC_IDX_RUNFLAGS, 8'h10);
            if (c == 3)
                dtc_pins_i.pulse(2, 24);
            else
                repeat (480) @(posedge clk_i);
            wr(`DTC_IDX_RUNFLAGS, 8'h00);
            wb(`DTC_IDX_CNT0_LOW, 1'b0, 8'h00, rv);
            chk_rng(rv, lo_t[c], hi_t[c]); // divided tick rate
        end
        $display("test prescaler done");
        // Split mode: timer 1 runs by its mode and sets no flag.
        wr(`DTC_IDX_CLKSEL, 8'h0c);
        wr(`DTC_IDX_CNT1_HIGH, 8'hff);
        wr(`DTC_IDX_CNT1_LOW, 8'h1f);
        wr(`DTC_IDX_MODE, 8'h03);
        wait_on(2); // pulse still given
        chk({7'h0, fl1}, 8'h00); // no flag from timer 1
        wr(`DTC_IDX_MODE, 8'h33);
        wb(`DTC_IDX_CNT1_LOW, 1'b0, 8'h00, rv);
        repeat (20) @(posedge clk_i);
        wb(`DTC_IDX_CNT1_LOW, 1'b0, 8'h00, rv2);
        chk(rv2, rv); // mode 3 stops timer 1
        wr(`DTC_IDX_CNT0_HIGH, 8'hfe);
        wr(`DTC_IDX_RUNFLAGS, 8'h40);
        wait_on(1); // high byte sets flag 1
        vec(1);
        chk({7'h0, fl1}, 8'h00); // cleared on vector
        wr(`DTC_IDX_RUNFLAGS, 8'h00);
        $display("test split done");
        give_verdict();
    end
endmodule
